// *** pkg/ulp_pkg.sv ***
package ulp_pkg;
    // command byte layout
    localparam int CMD_HI = 7;
    localparam int CMD_LO = 6;
    localparam logic [1:0] CMD_SPECIAL = 2'h0;
    localparam logic [1:0] CMD_TX      = 2'h1;
    localparam logic [1:0] CMD_REGW    = 2'h2;
    localparam logic [1:0] CMD_REGR    = 2'h3;
    localparam logic [5:0] PAYLOAD_RAW_TRANSMIT_NO_IDENTIFIER = 6'h00;
    localparam logic [7:0] BUS_IDLE    = 8'h00;
    // receive event codes
    localparam logic [1:0] EV_NONE    = 2'h0;
    localparam logic [1:0] EV_ACTIVE  = 2'h1;
    localparam logic [1:0] EV_ERROR   = 2'h3;
    localparam logic [1:0] LS_SE0     = 2'h0;
    // configuration
    localparam int CONFIG_HOLD_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS       = 10;
    localparam int CONFIG_HOLD_CYC     = (CONFIG_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] REF_DEFAULT = 3'h0;

    typedef enum logic [3:0] {
        ULP_IDLE    = 4'h0,
        ULP_TX      = 4'h1,
        ULP_TX_END  = 4'h2,
        ULP_WR_DATA = 4'h3,
        ULP_WR_STP  = 4'h4,
        ULP_RD_TURN = 4'h5,
        ULP_RD_DATA = 4'h6,
        ULP_TURN_UP = 4'h7,
        ULP_RXCMD   = 4'h8,
        ULP_RX      = 4'h9,
        ULP_TURN_DN = 4'hA,
        ULP_RD_GAP  = 4'hB
    } ulp_state_e;

    // receive side status from the transceiver
    typedef struct packed {
        logic       rx_valid;
        logic [7:0] rx_data;
        logic       receive_active_flag;
        logic       receive_error_flag;
        logic [1:0] line_state_bits;
    } ulp_usb_s;

    typedef struct packed {
        ulp_state_e state;
        logic       dir;
        logic       nxt;
        logic [7:0] dout;
        logic       oe;
        logic [1:0] ls_last;
        logic [1:0] ev_last;
        logic       rx_pend;
        logic       upd_pend;
        logic       eop_pend;
        logic [5:0] reg_addr;
        logic       reg_we;
        logic [5:0] we_addr;
        logic [7:0] we_data;
        logic       tx_start;
        logic       tx_valid;
        logic [7:0] tx_byte;
    } ulp_core_s;
endpackage

// *** verilog/ulp_phy_bus.sv ***
`timescale 1ns/1ps
// Operation
// - rx command: line state 1:0, event 5:4
// - event codes 00 idle, 01 active, 11 error
// - rx command after every transmit
// - back-to-back rx commands keep dir high
// - raw transmit: nxt in cmd, stop ends
// - nxt paces transmit bytes
// - receive from idle raises dir and nxt
// - receive with dir high: rx command first
// - nxt marks data; status when nxt low
// - deferred status update at packet end
// - register write: cmd, data, stop
// - read: nxt, dir, then data, nxt low
// - rx command aborts access except data
// - receive during read data is delayed
// - receive after read appended back to back
// - dir during write stop applies write
// - receive after read data: no turnaround, dir stays high
// - reset low at power-on enters config
// - reset high for hold time exits config
// - command code 7:6, payload 5:0
// - falling edge count selects reference
module ulp_phy_bus #(
    parameter int HOLD_CYC = ulp_pkg::CONFIG_HOLD_CYC
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [7:0]       data_in,
    output logic      [7:0]       data_out,
    output logic                  data_oe,
    input  wire logic             stp,
    output logic                  dir,
    output logic                  nxt,
    input  wire ulp_pkg::ulp_usb_s usb,
    input  wire logic [7:0]       reg_rdata,
    output logic      [5:0]       reg_addr,
    output logic                  reg_we,
    output logic      [7:0]       reg_wdata,
    output logic                  tx_start,
    output logic                  tx_valid,
    output logic      [7:0]       tx_byte,
    input  wire logic             power_on,
    input  wire logic             reset_n_pin,
    output logic                  config_mode,
    output logic      [2:0]       reference_select
);
    // refuse a hold count the counter cannot serve
    if (HOLD_CYC < 1) begin : g_hold_check
        $error("hold count must be positive");
    end

    // ----------------------------------------------------------------
    // bus protocol state
    // ----------------------------------------------------------------
    ulp_pkg::ulp_core_s s_r, s_nxt;
    logic [7:0] rxcmd;
    logic [1:0] ev_now;
    logic       chg;

    // current event code; 10 is never produced
    always_comb begin
        if (!usb.receive_active_flag)
            ev_now = ulp_pkg::EV_NONE;
        else if (usb.receive_error_flag)
            ev_now = ulp_pkg::EV_ERROR;
        else
            ev_now = ulp_pkg::EV_ACTIVE;
        rxcmd = {2'h0, ev_now, 2'h0, usb.line_state_bits};
        chg = (ev_now != s_r.ev_last) || (usb.line_state_bits != s_r.ls_last);
    end

    // main transition; status change gets queued when bus busy
    always_comb begin
        s_nxt = s_r;
        s_nxt.reg_we   = 1'b0;
        s_nxt.tx_start = 1'b0;
        s_nxt.tx_valid = 1'b0;
        s_nxt.nxt      = 1'b0;
        if (chg)
            s_nxt.upd_pend = 1'b1;
        if (usb.rx_valid)
            s_nxt.rx_pend = 1'b1;
        unique case (s_r.state)
            ulp_pkg::ULP_IDLE: begin
                s_nxt.oe = 1'b0;
                if (usb.receive_active_flag && s_r.ev_last == ulp_pkg::EV_NONE) begin
                    // abort anything on the bus, dir and nxt together
                    s_nxt.dir   = 1'b1;
                    s_nxt.nxt   = 1'b1;
                    s_nxt.ev_last = ev_now;
                    s_nxt.ls_last = usb.line_state_bits;
                    s_nxt.upd_pend = 1'b0;
                    s_nxt.state = ulp_pkg::ULP_TURN_UP;
                end else if (chg || s_r.upd_pend || s_r.eop_pend) begin
                    s_nxt.dir   = 1'b1;
                    s_nxt.state = ulp_pkg::ULP_TURN_UP;
                end else if (data_in[ulp_pkg::CMD_HI:ulp_pkg::CMD_LO] == ulp_pkg::CMD_TX) begin
                    s_nxt.nxt = 1'b1;
                    s_nxt.tx_start = 1'b1;
                    if (data_in[5:0] != ulp_pkg::PAYLOAD_RAW_TRANSMIT_NO_IDENTIFIER) begin
                        // pid goes out as the first usb byte
                        s_nxt.tx_valid = 1'b1;
                        s_nxt.tx_byte  = {~data_in[3:0], data_in[3:0]};
                    end
                    s_nxt.state = ulp_pkg::ULP_TX;
                end else if (data_in[ulp_pkg::CMD_HI:ulp_pkg::CMD_LO] == ulp_pkg::CMD_REGW) begin
                    s_nxt.nxt = 1'b1;
                    s_nxt.reg_addr = data_in[5:0];
                    s_nxt.state = ulp_pkg::ULP_WR_DATA;
                end else if (data_in[ulp_pkg::CMD_HI:ulp_pkg::CMD_LO] == ulp_pkg::CMD_REGR) begin
                    s_nxt.nxt = 1'b1;
                    s_nxt.reg_addr = data_in[5:0];
                    s_nxt.state = ulp_pkg::ULP_RD_TURN;
                end
            end
            ulp_pkg::ULP_TX: begin
                if (stp) begin
                    s_nxt.nxt = 1'b0;
                    s_nxt.eop_pend = 1'b1;
                    s_nxt.state = ulp_pkg::ULP_TX_END;
                end else begin
                    // byte held until the nxt just given is seen;
                    // the command byte itself still stands in the first cycle
                    s_nxt.nxt = 1'b1;
                    if (s_r.nxt && !s_r.tx_start) begin
                        s_nxt.tx_valid = 1'b1;
                        s_nxt.tx_byte  = data_in;
                    end
                end
            end
            ulp_pkg::ULP_TX_END: begin
                // force an rx command after the packet: last line state set to 11 so the current one counts as a change
                s_nxt.ls_last = ~ulp_pkg::LS_SE0;
                s_nxt.state = ulp_pkg::ULP_IDLE;
            end
            ulp_pkg::ULP_WR_DATA: begin
                if (chg || usb.receive_active_flag) begin
                    s_nxt.state = ulp_pkg::ULP_IDLE;
                end else begin
                    s_nxt.nxt = 1'b1;
                    s_nxt.state = ulp_pkg::ULP_WR_STP;
                end
            end
            ulp_pkg::ULP_WR_STP: begin
                // stop alone commits; a dir rise this cycle does not cancel it
                if (stp) begin
                    s_nxt.reg_we  = 1'b1;
                    s_nxt.we_addr = s_r.reg_addr;
                    s_nxt.state = ulp_pkg::ULP_IDLE;
                end else if (s_r.nxt) begin
                    // data byte stands in the cycle its nxt is high
                    s_nxt.we_data = data_in;
                end
            end
            ulp_pkg::ULP_RD_TURN: begin
                s_nxt.dir = 1'b1;
                s_nxt.state = ulp_pkg::ULP_RD_DATA;
            end
            ulp_pkg::ULP_RD_DATA: begin
                // read data wins over a receive arriving now
                s_nxt.oe   = 1'b1;
                s_nxt.dout = reg_rdata;
                s_nxt.state = ulp_pkg::ULP_RD_GAP;
            end
            ulp_pkg::ULP_RD_GAP: begin
                if (usb.receive_active_flag || s_r.rx_pend) begin
                    s_nxt.dout = rxcmd;
                    s_nxt.ev_last = ev_now;
                    s_nxt.ls_last = usb.line_state_bits;
                    s_nxt.upd_pend = 1'b0;
                    s_nxt.state = ulp_pkg::ULP_RX;
                end else begin
                    s_nxt.dir = 1'b0;
                    s_nxt.oe  = 1'b0;
                    s_nxt.state = ulp_pkg::ULP_TURN_DN;
                end
            end
            ulp_pkg::ULP_TURN_UP: begin
                s_nxt.oe = 1'b1;
                s_nxt.nxt = 1'b0;
                s_nxt.state = ulp_pkg::ULP_RXCMD;
                s_nxt.dout = rxcmd;
                s_nxt.ev_last = ev_now;
                s_nxt.ls_last = usb.line_state_bits;
                s_nxt.upd_pend = 1'b0;
                s_nxt.eop_pend = 1'b0;
                // no buffer: a byte right after a receive from idle goes out at once
                if (usb.rx_valid && s_r.nxt) begin
                    s_nxt.nxt  = 1'b1;
                    s_nxt.dout = usb.rx_data;
                    s_nxt.rx_pend = 1'b0;
                    s_nxt.state = ulp_pkg::ULP_RX;
                end
            end
            ulp_pkg::ULP_RXCMD, ulp_pkg::ULP_RX: begin
                if (usb.rx_valid) begin
                    s_nxt.nxt  = 1'b1;
                    s_nxt.dout = usb.rx_data;
                    s_nxt.rx_pend = 1'b0;
                    s_nxt.state = ulp_pkg::ULP_RX;
                end else if (chg || s_r.upd_pend || usb.receive_active_flag) begin
                    // current values only, older changes folded in
                    s_nxt.dout = rxcmd;
                    s_nxt.ev_last = ev_now;
                    s_nxt.ls_last = usb.line_state_bits;
                    s_nxt.upd_pend = 1'b0;
                end else begin
                    s_nxt.dir = 1'b0;
                    s_nxt.oe  = 1'b0;
                    s_nxt.state = ulp_pkg::ULP_TURN_DN;
                end
            end
            ulp_pkg::ULP_TURN_DN: begin
                s_nxt.oe = 1'b0;
                s_nxt.state = ulp_pkg::ULP_IDLE;
            end
            default: s_nxt.state = ulp_pkg::ULP_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // configuration by reset pin pulses
    // ----------------------------------------------------------------
    // hold counter long enough for the hold time; pulse count wraps at 8
    logic        cfg_r, cfg_nxt;
    logic        armed_r, armed_nxt;
    logic        pin_r;
    logic [2:0]  cnt_r, cnt_nxt;
    logic [2:0]  ref_r, ref_nxt;
    logic [$clog2(HOLD_CYC+1)-1:0] hold_r, hold_nxt;

    always_comb begin
        cfg_nxt = cfg_r;
        armed_nxt = armed_r;
        cnt_nxt = cnt_r;
        ref_nxt = ref_r;
        hold_nxt = hold_r;
        if (!power_on) begin
            armed_nxt = 1'b1;
            hold_nxt = '0;
            cfg_nxt = 1'b0;
        end else if (!cfg_r) begin
            if (armed_r && !reset_n_pin) begin
                hold_nxt = hold_r + 1'b1;
                if (hold_r == $bits(hold_r)'(HOLD_CYC - 1)) begin
                    cfg_nxt = 1'b1;
                    armed_nxt = 1'b0;
                    cnt_nxt = '0;
                    hold_nxt = '0;
                end
            end else begin
                armed_nxt = 1'b0;
                hold_nxt = '0;
            end
        end else begin
            if (pin_r && !reset_n_pin)
                cnt_nxt = cnt_r + 1'b1;
            if (reset_n_pin) begin
                hold_nxt = hold_r + 1'b1;
                if (hold_r == $bits(hold_r)'(HOLD_CYC - 1)) begin
                    cfg_nxt = 1'b0;
                    ref_nxt = cnt_r;
                end
            end else begin
                hold_nxt = '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_r <= 1'b0;
            armed_r <= 1'b0;
            pin_r <= 1'b1;
            cnt_r <= '0;
            ref_r <= ulp_pkg::REF_DEFAULT;
            hold_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
            armed_r <= armed_nxt;
            pin_r <= reset_n_pin;
            cnt_r <= cnt_nxt;
            ref_r <= ref_nxt;
            hold_r <= hold_nxt;
        end
    end

    // outputs straight from flip-flops
    assign data_out = s_r.dout;
    assign data_oe = s_r.oe;
    assign dir = s_r.dir;
    assign nxt = s_r.nxt;
    assign reg_addr = s_r.reg_addr;
    assign reg_we = s_r.reg_we;
    assign reg_wdata = s_r.we_data;
    assign tx_start = s_r.tx_start;
    assign tx_valid = s_r.tx_valid;
    assign tx_byte = s_r.tx_byte;
    assign config_mode = cfg_r;
    assign reference_select = ref_r;
endmodule

// *** tb/ulp_phy_bus_props.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus protocol checker
// ------------------------------------------------------------
module ulp_props #(
    parameter int HOLD_CYC = ulp_pkg::CONFIG_HOLD_CYC
) (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       stp,
    input wire logic       dir,
    input wire logic       nxt,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_we,
    input wire logic       power_on,
    input wire logic       reset_n_pin,
    input wire logic       config_mode,
    input wire logic [2:0] reference_select
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    int hi_cnt_r;
    // cycles the reset pin has stood high
    always_ff @(posedge clock) begin
        hi_cnt_r <= reset_n_pin ? hi_cnt_r + 1 : 0;
    end
    // bus handover needs one quiet cycle
    a_turn_quiet: assert property ($changed(dir) |-> !data_oe)
        else $error("bus driven in turnaround");
    a_oe_with_dir: assert property (data_oe |-> dir)
        else $error("bus driven without dir");
    a_turn_no_nxt: assert property ($rose(dir) && !nxt |=> !nxt)
        else $error("nxt in turnaround");
    a_read_data: assert property ($rose(dir) && !nxt && $past(nxt) && !$past(nxt, 2)
        |=> data_oe && !nxt && data_out == $past(reg_rdata))
        else $error("read data wrong");
    a_we_after_stp: assert property (reg_we |-> $past(stp))
        else $error("write without stop");
    a_we_pulse: assert property (reg_we |=> !reg_we)
        else $error("write strobe too long");
    a_stp_ends_nxt: assert property (stp && !dir |=> !nxt || dir)
        else $error("nxt after stop");
    a_cfg_entry: assert property ($rose(config_mode) |-> power_on && !$past(reset_n_pin))
        else $error("config entered wrongly");
    a_cfg_exit: assert property ($fell(config_mode) |-> hi_cnt_r >= HOLD_CYC - 1)
        else $error("config left early");
    a_ref_held: assert property (!config_mode && !$past(config_mode) |-> $stable(reference_select))
        else $error("reference changed outside config");
endmodule
bind ulp_phy_bus ulp_props #(.HOLD_CYC(HOLD_CYC)) u_props (
    .clock(clock), .sys_rst(sys_rst), .data_out(data_out), .data_oe(data_oe), .stp(stp), .dir(dir),
    .nxt(nxt), .reg_rdata(reg_rdata), .reg_we(reg_we), .power_on(power_on), .reset_n_pin(reset_n_pin),
    .config_mode(config_mode), .reference_select(reference_select)
);

// *** tb/ulp_link_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// link controller model
// ------------------------------------------------------------
module ulp_link_model (
    input  wire logic       clock,
    input  wire logic       dir,
    input  wire logic       nxt,
    input  wire logic [7:0] data_out,
    output logic      [7:0] data_in,
    output logic            stp
);
    logic [7:0] drv;
    int         fails;
    // released bus shows the inverse, never a stale copy
    assign data_in = dir ? ~drv : drv;
    initial begin
        drv = ulp_pkg::BUS_IDLE;
        stp = 1'b0;
        fails = 0;
    end
    // hold a byte until nxt is sampled high with dir low;
    // a command cut off by dir is simply offered again once the bus is idle
    task automatic send(input logic [7:0] b);
        int n;
        drv = b;
        n = 0;
        while (!(nxt === 1'b1 && dir === 1'b0) && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 40) fails++;
        @(posedge clock);
        #1;
    endtask
    // one-cycle stop with idle data
    task automatic stop();
        drv = ulp_pkg::BUS_IDLE;
        stp = 1'b1;
        @(posedge clock);
        #1;
        stp = 1'b0;
    endtask
    // read: command, hand bus over, take the byte after turnaround
    task automatic read(input logic [5:0] a, output logic [7:0] d);
        int n;
        send({ulp_pkg::CMD_REGR, a});
        drv = ulp_pkg::BUS_IDLE;
        n = 0;
        while (dir !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        #1;
        d = data_out;
    endtask
endmodule

// *** tb/ulp_phy_bus_tb_top.sv ***
`timescale 1ns/1ps
module ulp_phy_bus_tb_top;
    localparam int HOLD = 4;
    logic              clock;
    logic              sys_rst;
    logic        [7:0] data_in;
    logic        [7:0] data_out;
    logic              data_oe;
    logic              stp;
    logic              dir;
    logic              nxt;
    ulp_pkg::ulp_usb_s usb;
    logic        [7:0] reg_rdata;
    logic        [5:0] reg_addr;
    logic              reg_we;
    logic        [7:0] reg_wdata;
    logic              tx_start;
    logic              tx_valid;
    logic        [7:0] tx_byte;
    logic              power_on;
    logic              reset_n_pin;
    logic              config_mode;
    logic        [2:0] reference_select;
    logic        [7:0] rd;
    logic       [15:0] txq[$];
    logic       [15:0] wq[$];
    logic       [15:0] rxq[$];
    int                miscompares = 0;
    int                checks = 0;
    int                seed = 28;
    int                cyc = 0;
    int                starts = 0;
    ulp_phy_bus #(.HOLD_CYC(HOLD)) uut (
        .clock(clock), .sys_rst(sys_rst), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .stp(stp), .dir(dir), .nxt(nxt), .usb(usb), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_we(reg_we), .reg_wdata(reg_wdata), .tx_start(tx_start), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .power_on(power_on), .reset_n_pin(reset_n_pin), .config_mode(config_mode),
        .reference_select(reference_select)
    );
    ulp_link_model link (
        .clock(clock), .dir(dir), .nxt(nxt), .data_out(data_out), .data_in(data_in), .stp(stp)
    );
    initial clock = 1'b0;
    always #5 clock = ~clock;
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [15:0] pop(ref logic [15:0] q[$]);
        return q.size() > 0 ? q.pop_front() : 16'hFFFF;
    endfunction
    // model side: every byte handed on is matched against the queues
    always @(posedge clock) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            close_out();
        end
        if (tx_start === 1'b1) starts++;
        if (tx_valid === 1'b1) chk("tx byte", {8'h00, tx_byte}, pop(txq));
        if (reg_we === 1'b1) chk("reg write", {2'b00, reg_addr, reg_wdata}, pop(wq));
        if (dir === 1'b1 && nxt === 1'b1 && data_oe === 1'b1) chk("rx byte", {8'h00, data_out}, pop(rxq));
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_dir(input logic v);
        int n;
        n = 0;
        do begin
            step(1);
            n++;
        end while (dir !== v && n < 40);
    endtask
    task automatic wait_rxcmd(input logic [7:0] b);
        int n;
        n = 0;
        do begin
            step(1);
            n++;
        end while (!(dir === 1'b1 && data_oe === 1'b1 && nxt === 1'b0 && data_out === b) && n < 60);
        chk("rx command", {8'h00, data_out}, {8'h00, b});
    endtask
    task automatic write(input logic [5:0] a, input logic [7:0] d);
        wq.push_back({2'b00, a, d});
        link.send({ulp_pkg::CMD_REGW, a});
        link.send(d);
        link.stop();
        step(3);
    endtask
    task automatic read(input logic [5:0] a);
        reg_rdata = 8'($random(seed));
        link.read(a, rd);
        chk("read data", {8'h00, rd}, {8'h00, reg_rdata});
        step(3);
    endtask
    // transmit: pid byte first when present, then paced data, then stop
    task automatic transmit(input logic [3:0] pid, input int len);
        logic [7:0] b;
        if (pid != 4'h0) txq.push_back({8'h00, ~pid, pid});
        link.send({ulp_pkg::CMD_TX, 2'b00, pid});
        repeat (len) begin
            b = 8'($random(seed));
            txq.push_back({8'h00, b});
            link.send(b);
        end
        link.stop();
        chk("nxt after stop", {15'h0, nxt}, 16'h0);
        wait_rxcmd({2'b00, ulp_pkg::EV_NONE, 2'b00, usb.line_state_bits});
        step(4);
    endtask
    // receive from an idle bus, then an error mid-packet
    task automatic receive(input int len);
        logic [7:0] b;
        usb.receive_active_flag = 1'b1;
        wait_dir(1'b1);
        chk("nxt with dir", {15'h0, nxt}, 16'h1);
        repeat (len) begin
            b = 8'($random(seed));
            rxq.push_back({8'h00, b});
            usb.rx_valid = 1'b1;
            usb.rx_data = b;
            step(1);
            usb.rx_valid = 1'b0;
            step(2);
        end
        usb.receive_error_flag = 1'b1;
        wait_rxcmd({2'b00, ulp_pkg::EV_ERROR, 2'b00, 2'b01});
        usb.receive_active_flag = 1'b0;
        usb.receive_error_flag = 1'b0;
        wait_dir(1'b0);
        chk("dir after receive", {15'h0, dir}, 16'h0);
        step(4);
    endtask
    // power cycle into configuration, count pulses, leave
    task automatic configure(input int pulses);
        power_on = 1'b0;
        reset_n_pin = 1'b0;
        step(2);
        power_on = 1'b1;
        step(HOLD + 2);
        chk("config mode", {15'h0, config_mode}, 16'h1);
        repeat (pulses) begin
            reset_n_pin = 1'b1;
            step(1);
            reset_n_pin = 1'b0;
            step(1);
        end
        reset_n_pin = 1'b1;
        step(HOLD + 2);
        chk("config exit", {15'h0, config_mode}, 16'h0);
        chk("reference", {13'h0, reference_select}, 16'(pulses));
    endtask
    // main sequence
    initial begin
        sys_rst = 1'b1;
        usb = '0;
        usb.line_state_bits = 2'b01;
        reg_rdata = 8'h00;
        power_on = 1'b1;
        reset_n_pin = 1'b1;
        step(8);
        sys_rst = 1'b0;
        chk("idle outputs", {6'h0, dir, nxt, data_oe, reg_we, tx_start, tx_valid, config_mode, reference_select},
            16'h0);
        step(2);
        repeat (3) write(6'($random(seed)), 8'($random(seed)));
        repeat (3) read(6'($random(seed)));
        transmit(4'h0, 2);
        transmit(4'($random(seed)) | 4'h1, 3);
        usb.line_state_bits = 2'b10;
        step(1);
        usb.line_state_bits = 2'b11;
        wait_rxcmd({2'b00, ulp_pkg::EV_NONE, 2'b00, 2'b11});
        usb.line_state_bits = 2'b01;
        step(8);
        receive(4);
        for (int i = 0; i < 8; i++) configure(i);
        chk("queues left", 16'(txq.size() + wq.size() + rxq.size()), 16'h0);
        chk("link waits", 16'(link.fails), 16'h0);
        chk("tx starts", 16'(starts), 16'h2);
        close_out();
    end
endmodule
